// [srs_pkg.sv]
// package of constants and types for the startup reset sequencer
// ============================================================
// Function
// R1: reset held while external or power-on reset
// R2: power-on reset lasts 3 ms, never under 1.5 ms
// R3: no boot while external reset held
// R4: clock request about 120 us after release
// R5: sleep at least 4.2 ms after release
// R6: reference and low-power clocks stable by then
// R7: missing low-power clock switches to internal one
// R8: delays are parameter counters on known clock
package srs_pkg;
    // ============================================================
    // clock rate and times
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned POR_TYP_US     = 3000;
    localparam int unsigned POR_MIN_US     = 1500;
    localparam int unsigned CLKREQ_US      = 120;
    localparam int unsigned SLEEP_MIN_US   = 4200;
    localparam int unsigned LPC_WATCH_US   = 100;
    localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
    localparam int unsigned POR_CYC        = POR_TYP_US * CYC_PER_US;
    localparam int unsigned POR_MIN_CYC    = POR_MIN_US * CYC_PER_US;
    localparam int unsigned CLKREQ_CYC     = CLKREQ_US * CYC_PER_US;
    localparam int unsigned SLEEP_CYC      = SLEEP_MIN_US * CYC_PER_US;
    localparam int unsigned LPC_WATCH_CYC  = LPC_WATCH_US * CYC_PER_US;
    localparam int unsigned CNT_W          = 24;

    // ============================================================
    // sequencer states
    typedef enum logic [1:0] {
        SRS_RESET,
        SRS_SLEEP,
        SRS_RUN
    } srs_state_t;

    // status bundle driven out
    typedef struct packed {
        logic chip_reset;
        logic clk_req;
        logic boot_go;
        logic lpc_internal;
    } srs_status_t;
endpackage

// [srs_sequencer.sv]
// startup and reset sequencer of the radio baseband
`timescale 1ns/100ps
module srs_sequencer #(
    parameter int unsigned POR_CYC       = srs_pkg::POR_CYC,
    parameter int unsigned CLKREQ_CYC    = srs_pkg::CLKREQ_CYC,
    parameter int unsigned SLEEP_CYC     = srs_pkg::SLEEP_CYC,
    parameter int unsigned LPC_WATCH_CYC = srs_pkg::LPC_WATCH_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // external reset and supply monitor
    input  wire logic                 ext_reset_n,
    input  wire logic                 core_supply_ok,
    // low-power clock sample and internal substitute
    input  wire logic                 low_power_clock_in,
    input  wire logic                 internal_lpc,
    // outputs
    output srs_pkg::srs_status_t      status,
    output logic                      low_power_clock
);
    localparam int W = srs_pkg::CNT_W;
    // shortest power-on reset allowed, scaled to the typical count
    localparam int unsigned POR_MIN = POR_CYC * srs_pkg::POR_MIN_US
                                      / srs_pkg::POR_TYP_US;

    // ============================================================
    // shared counter compare
    // true once a counter has reached a cycle limit
    function automatic logic at_limit(input logic [W-1:0] cnt,
                                      input int unsigned lim);
        return cnt >= W'(lim);
    endfunction

    // ============================================================
    // power-on reset counter
    logic [W-1:0] por_cnt;
    logic         por_active;
    wire          por_done = at_limit(por_cnt, POR_CYC);

    // R2: hold power-on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_cnt <= '0;
        end else if (!core_supply_ok) begin
            por_cnt <= '0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + W'(1);
        end
    end
    assign por_active = !por_done;

    // R1: combined global reset, last release wins
    wire glob_reset = por_active || !ext_reset_n;

    // ============================================================
    // sequencer
    srs_pkg::srs_state_t state;
    srs_pkg::srs_state_t next_state;
    logic [W-1:0]        seq_cnt;
    wire sleep_done = at_limit(seq_cnt, SLEEP_CYC - 1);
    wire req_due    = at_limit(seq_cnt, CLKREQ_CYC - 1);

    // R3: startup waits for external reset release
    always_comb begin
        next_state = state;
        unique case (state)
            srs_pkg::SRS_RESET: begin
                if (!glob_reset) next_state = srs_pkg::SRS_SLEEP;
            end
            srs_pkg::SRS_SLEEP: begin
                if (glob_reset) next_state = srs_pkg::SRS_RESET;
                else if (sleep_done) next_state = srs_pkg::SRS_RUN;
            end
            srs_pkg::SRS_RUN: begin
                if (glob_reset) next_state = srs_pkg::SRS_RESET;
            end
            // unused code falls back to reset
            default: begin
                next_state = srs_pkg::SRS_RESET;
            end
        endcase
    end

    // R8: sequencer state and delay counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= srs_pkg::SRS_RESET;
            seq_cnt <= '0;
        end else begin
            state <= next_state;
            if (next_state == srs_pkg::SRS_RESET) seq_cnt <= '0;
            else if (!(&seq_cnt)) seq_cnt <= seq_cnt + W'(1);
        end
    end

    // ============================================================
    // low-power clock watchdog
    logic         lpc_prev;
    logic [W-1:0] lpc_idle;
    logic         use_internal;
    wire          lpc_edge = low_power_clock_in ^ lpc_prev;
    wire          lpc_quiet = at_limit(lpc_idle, LPC_WATCH_CYC);

    // R7: no edges for watch time selects internal clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lpc_prev     <= 1'b0;
            lpc_idle     <= '0;
            use_internal <= 1'b0;
        end else begin
            lpc_prev <= low_power_clock_in;
            if (lpc_edge) lpc_idle <= '0;
            else if (!lpc_quiet) lpc_idle <= lpc_idle + W'(1);
            // a stall seen this cycle wins over a fresh edge
            if (lpc_quiet) use_internal <= 1'b1;
            else if (lpc_edge) use_internal <= 1'b0;
        end
    end

    // ============================================================
    // registered outputs
    wire in_seq = (next_state != srs_pkg::SRS_RESET);

    // R4: clock request after delay; R5: boot after sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status          <= '{1'b1, 1'b0, 1'b0, 1'b0};
            low_power_clock <= 1'b0;
        end else begin
            status.chip_reset   <= !in_seq;
            status.clk_req      <= in_seq && req_due;
            status.boot_go      <= next_state == srs_pkg::SRS_RUN;
            status.lpc_internal <= use_internal;
            low_power_clock <= use_internal ? internal_lpc
                                            : low_power_clock_in;
        end
    end

    // ============================================================
    // check helpers, counted apart from the sequencer's own counters
    logic [W-1:0] sup_run;
    logic [W-1:0] rel_run;

    // cycles of good supply and cycles since the chip left reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sup_run <= '0;
            rel_run <= '0;
        end else begin
            if (!core_supply_ok) sup_run <= '0;
            else if (!(&sup_run)) sup_run <= sup_run + W'(1);
            if (status.chip_reset) rel_run <= '0;
            else if (!(&rel_run)) rel_run <= rel_run + W'(1);
        end
    end

    // ============================================================
    // checks
    // R1: external reset keeps chip in reset
    ext_hold_a: assert property (@(posedge clk) disable iff (rst) // R1
        !ext_reset_n |=> status.chip_reset)
        else $error("chip left reset while external reset held");
    // R3: no boot while external reset
    boot_block_a: assert property (@(posedge clk) disable iff (rst) // R3
        !ext_reset_n |=> !status.boot_go)
        else $error("boot while external reset held");
    // R5: boot only after full sleep
    sleep_min_a: assert property (@(posedge clk) disable iff (rst) // R5
        $rose(status.boot_go) |-> seq_cnt >= W'(SLEEP_CYC - 1))
        else $error("boot before minimum sleep");
    // R4: clock request not before delay
    clk_req_a: assert property (@(posedge clk) disable iff (rst) // R4
        $rose(status.clk_req) |-> $past(seq_cnt) >= W'(CLKREQ_CYC - 1))
        else $error("clock request too early");
    // R2: power-on reset minimum length
    por_min_a: assert property (@(posedge clk) disable iff (rst) // R2
        $fell(por_active) |-> at_limit(sup_run, POR_MIN))
        else $error("power-on reset too short");
    // R1: reset drops clock request and boot
    reset_drop_a: assert property (@(posedge clk) disable iff (rst) // R1
        status.chip_reset |-> !status.clk_req && !status.boot_go)
        else $error("request or boot during reset");
    // R7: idle input selects internal clock
    lpc_switch_a: assert property (@(posedge clk) disable iff (rst) // R7
        lpc_quiet |-> ##2 status.lpc_internal)
        else $error("internal clock not selected");
    // R8: sequence restarts in reset
    restart_a: assert property (@(posedge clk) disable iff (rst) // R8
        glob_reset |=> seq_cnt == '0)
        else $error("delay counter not cleared");

    // ============================================================
    // reset, timing and clock selection checks
    // R1: pending power-on reset holds the chip
    por_hold_a: assert property (@(posedge clk) disable iff (rst) // R1
        por_active |=> status.chip_reset)
        else $error("chip left reset during power-on reset");
    // R1: any reset source clears the request
    req_drop_a: assert property (@(posedge clk) disable iff (rst) // R1
        glob_reset |=> status.chip_reset && !status.clk_req)
        else $error("request kept through reset");
    // R4: request exactly at its delay
    req_time_a: assert property (@(posedge clk) disable iff (rst) // R4
        !status.chip_reset |->
            status.clk_req == at_limit(rel_run, CLKREQ_CYC - 1))
        else $error("clock request off its delay");
    // R5: boot exactly when sleep ends
    boot_time_a: assert property (@(posedge clk) disable iff (rst) // R5
        !status.chip_reset |->
            status.boot_go == at_limit(rel_run, SLEEP_CYC - 1))
        else $error("boot off the sleep period");
    // R4: clock request comes before boot
    req_order_a: assert property (@(posedge clk) disable iff (rst) // R4
        status.boot_go |-> status.clk_req)
        else $error("boot without clock request");
    // R7: a fresh edge returns to the external clock
    lpc_back_a: assert property (@(posedge clk) disable iff (rst) // R7
        lpc_edge && !lpc_quiet |-> ##2 !status.lpc_internal)
        else $error("external clock not taken back");
    // R7: internal source drives the clock output
    lpc_int_a: assert property (@(posedge clk) disable iff (rst) // R7
        status.lpc_internal |-> low_power_clock == $past(internal_lpc))
        else $error("internal clock not passed out");
    // R7: external source drives the clock output
    lpc_ext_a: assert property (@(posedge clk) disable iff (rst) // R7
        !status.lpc_internal |-> low_power_clock == lpc_prev)
        else $error("external clock not passed out");
endmodule

// [srs_far_side.sv]
// far-side model: external reset source and low-power clock oscillator
`timescale 1ns/100ps
module srs_far_side (
    // clock and commands from the bench
    input  wire logic clk,
    input  wire logic hold_reset,
    input  wire logic lpc_run,
    // pins toward the sequencer
    output logic      ext_reset_n,
    output logic      low_power_clock_in
);
    logic [1:0] div = 2'h0;
    initial ext_reset_n = 1'b0;
    initial low_power_clock_in = 1'b0;
    always @(posedge clk) begin
        div <= #1 div + 2'h1;
        ext_reset_n <= #1 !hold_reset;
        if (lpc_run) begin
            low_power_clock_in <= #1 div[1];
        end
    end
endmodule

// [tb_startup_reset_sequencer.sv]
// self-checking bench of the startup reset sequencer
`timescale 1ns/100ps
module tb_startup_reset_sequencer;
    // ============================================================
    // clock, stimulus and design
    localparam int POR = 20, CRQ = 5, SLP = 30, WCH = 8;
    logic clk = 1'b0, rst = 1'b1, supply = 1'b1, ilpc = 1'b0;
    logic hold = 1'b1, run = 1'b1, ext_n, lpc_in, lpc_out, pi, px;
    srs_pkg::srs_status_t st, last;
    logic [3:0] exp_q[$];
    int gap_q[$];
    int miscompares = 0, samples_checked = 0, gap = 0, stable = 0, k, g;
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) ilpc <= #1 1'($urandom);
    srs_far_side far (.clk(clk), .hold_reset(hold), .lpc_run(run),
        .ext_reset_n(ext_n), .low_power_clock_in(lpc_in));
    srs_sequencer #(.POR_CYC(POR), .CLKREQ_CYC(CRQ), .SLEEP_CYC(SLP),
        .LPC_WATCH_CYC(WCH)) dut (.clk(clk), .rst(rst),
        .ext_reset_n(ext_n), .core_supply_ok(supply),
        .low_power_clock_in(lpc_in), .internal_lpc(ilpc),
        .status(st), .low_power_clock(lpc_out));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // note a status change; spacing 0 means any spacing
    task automatic note(input logic [3:0] s, input int sp);
        exp_q.push_back(s);
        gap_q.push_back(sp);
    endtask
    task automatic drain();
        for (k = 0; k < 400 && exp_q.size() > 0; k++) tick(1);
        if (exp_q.size() > 0) begin
            miscompares++;
            summarize();
        end
    endtask
    // match each status change with the oldest note
    always @(posedge clk) begin
        #2;
        gap++;
        if (rst) begin
            last = st;
            gap = 0;
            stable = 0;
        end else if (st !== last) begin
            if (exp_q.size() == 0) check(st, last);
            else begin
                check(st, exp_q.pop_front());
                g = gap_q.pop_front();
                if (g != 0) check(gap, g);
            end
            last = st;
            gap = 0;
            stable = 0;
        end else begin
            stable++;
            if (stable > 1) check(lpc_out, st.lpc_internal ? pi : px);
        end
        pi = ilpc;
        px = lpc_in;
    end
    // ============================================================
    // scenarios
    initial begin
        void'($urandom(34));
        tick(20);
        rst = 1'b0;
        tick(60);
        // release, then reassert at a random point of sleep
        hold = 1'b0;
        note(4'h0, 0);
        note(4'h4, CRQ - 1);
        tick(CRQ + 2 + $urandom_range(SLP - CRQ - 6));
        hold = 1'b1;
        note(4'h8, 0);
        drain();
        tick(30);
        // full sleep after a clean release
        hold = 1'b0;
        note(4'h0, 0);
        note(4'h4, CRQ - 1);
        note(4'h6, SLP - CRQ);
        drain();
        // power-on reset counted from supply good
        supply = 1'b0;
        rst = 1'b1;
        tick(2);
        check(st, 4'h8);
        rst = 1'b0;
        tick(3);
        supply = 1'b1;
        note(4'h0, 0);
        note(4'h4, CRQ - 1);
        note(4'h6, SLP - CRQ);
        for (k = 0; k < 100 && st.chip_reset; k++) tick(1);
        check(k, POR + 1);
        drain();
        // silent low-power clock swaps to the internal one
        run = 1'b0;
        note(4'h7, 0);
        drain();
        tick(20);
        run = 1'b1;
        note(4'h6, 0);
        drain();
        tick(10);
        summarize();
    end
endmodule
